// ### hw/nfc_mode_pkg.sv
// Constants, types and field layout of the protocol mode configuration bank.
// Assumes an 8-bit register port and a single device clock.
package nfc_mode_pkg;
	localparam int REG_W = 8;
	localparam int CODE_W = 4;
	// Register offsets
	localparam logic [7:0] MODE_ADDR = 8'h03;
	localparam logic [7:0] RATE_ADDR = 8'h04;
	localparam logic [7:0] TYPEA_ADDR = 8'h05;
	// Reset and set-default values, and the mode register write mask
	localparam logic [7:0] MODE_RESET = 8'h08;
	localparam logic [7:0] RATE_RESET = 8'h00;
	localparam logic [7:0] TYPEA_RESET = 8'h00;
	localparam logic [7:0] MODE_RW_MASK = 8'hF9;
	// Field positions
	localparam int ROLE_BIT = 7;
	localparam int OPCODE_MSB = 6;
	localparam int OPCODE_LSB = 3;
	localparam int AUTO_CA_BIT = 0;
	localparam int TX_RATE_MSB = 7;
	localparam int TX_RATE_LSB = 4;
	localparam int RX_RATE_MSB = 3;
	localparam int RX_RATE_LSB = 0;
	localparam int NO_TX_PAR_BIT = 7;
	localparam int NO_RX_PAR_BIT = 6;
	localparam int HDR_BIT = 5;
	localparam int PW_MSB = 4;
	localparam int PW_LSB = 1;
	localparam int ANTICOLL_BIT = 0;
	localparam logic [7:0] TRANSPORT_START_BYTE = 8'hF0;
	// Speed codes; fc/128 is a divide by 2^7
	localparam logic [3:0] RATE_FC128 = 4'h0;
	localparam logic [3:0] RATE_FC64 = 4'h1;
	localparam logic [3:0] RATE_FC32 = 4'h2;
	localparam logic [3:0] RATE_FC16 = 4'h3;
	localparam logic [2:0] DIV_LOG2_FC128 = 3'h7;
	// Operation codes
	localparam logic [3:0] OP_NFC_ACTIVE = 4'h0;
	localparam logic [3:0] OP_TYPE_A = 4'h1;
	localparam logic [3:0] OP_TYPE_B = 4'h2;
	localparam logic [3:0] OP_JP = 4'h3;
	localparam logic [3:0] OP_T1T = 4'h4;
	localparam logic [3:0] OP_SUBC = 4'hE;
	localparam logic [3:0] OP_BPSK = 4'hF;
	localparam logic [3:0] OP_TGT_AUTORATE = 4'h0;
	localparam logic [3:0] OP_TGT_NORMAL = 4'h1;
	// Pulse width centres per speed and the fc/64 fold base, in carrier periods
	localparam logic [6:0] PW_BASE_FC128 = 7'h23;
	localparam logic [6:0] PW_BASE_FC64 = 7'h12;
	localparam logic [6:0] PW_FOLD_FC64 = 7'h1A;
	localparam logic [6:0] PW_BASE_FC32 = 7'h09;
	localparam logic [6:0] PW_BASE_FC16 = 7'h05;

	typedef enum logic [3:0] {
		PROTO_NONE, PROTO_NFC_ACTIVE, PROTO_TYPE_A, PROTO_TYPE_B, PROTO_JP, PROTO_T1T,
		PROTO_SUBC_STREAM, PROTO_BPSK_STREAM, PROTO_TGT_AUTORATE, PROTO_TGT_NORMAL
	} protocol_t;

	typedef struct packed {
		logic target;
		protocol_t proto;
	} mode_sel_t;

	typedef struct packed {
		logic [2:0] tx_div_log2;
		logic [2:0] rx_div_log2;
	} rate_sel_t;

	typedef struct packed {
		logic tx_parity_off;
		logic rx_raw;
		logic transport_header;
		logic anticoll_frame;
		logic pulse_width_valid;
		logic [6:0] pulse_width;
	} framing_t;
endpackage

// ### hw/speed_code_decode.sv
// Decodes one four-bit speed code into a carrier divider exponent.
// Assumes the code comes from a register on the same clock.
`timescale 1ns/1ns
`default_nettype none
module speed_code_decode #(
	parameter int W = 4
) (
	// Code in
	input wire logic [W-1:0] code_i,
	// Decoded
	output logic valid_o,
	output logic [2:0] div_log2_o
);
	import nfc_mode_pkg::*;

	assign valid_o = (code_i[W-1:2] == '0);
	assign div_log2_o = valid_o ? 3'(DIV_LOG2_FC128 - code_i[2:0]) : 3'h0;
endmodule
`default_nettype wire

// ### hw/level_sync3.sv
// Three-stage synchroniser that accepts a new level once stages two and three agree.
// Assumes the input is asynchronous to the clock.
`timescale 1ns/1ns
`default_nettype none
module level_sync3 (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Level
	input wire logic d_i,
	output logic q_o
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			q_o <= 1'b0;
		end else begin
			s1_q <= d_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				q_o <= s3_q;
			end
		end
	end
endmodule
`default_nettype wire

// ### hw/nfc_protocol_mode_config.sv
// Protocol mode, speed and type A framing configuration registers.
// Assumes a host register port on core_clk_i and commands from on-chip logic.
// Behaviour
// - Bit 7 selects initiator or target role.
// - Initiator opcode picks one of seven modes.
// - Target opcodes pick auto-rate or normal active.
// - Unassigned opcode for role disables transmit/receive.
// - Auto-avoid bit starts collision avoidance on field loss.
// - Power-up and set-default load default values.
// - High nibble transmit speed, low nibble receive.
// - Codes 0..3 give fc/128 down to fc/16.
// - Other speed codes disable transmit and receive.
// - Go-normal command loads speed register from hardware.
// - No-parity transmit sends raw stream, host uses no-CRC.
// - Raw receive skips parity/CRC; host clears outside A.
// - Transport header adds F0 and length, strips F0.
// - Pulse width code counts carrier periods per speed.
// - Pulse width centres 35, 18, 9, 5 periods.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module nfc_protocol_mode_config (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// Commands from the command decoder
	input wire logic set_default_cmd_i,
	input wire logic go_normal_cmd_i,
	input wire logic [7:0] detected_rate_i,
	// External field detector
	input wire logic ext_field_i,
	// Configuration towards framing and RF logic
	output nfc_mode_pkg::mode_sel_t mode_o,
	output nfc_mode_pkg::rate_sel_t rate_o,
	output nfc_mode_pkg::framing_t framing_o,
	output logic txrx_enable_o,
	output logic [7:0] start_byte_o,
	output logic collision_avoid_start_o
);
	import nfc_mode_pkg::*;

	logic [7:0] mode_q;
	logic [7:0] mode_d;
	logic [7:0] rate_q;
	logic [7:0] rate_d;
	logic [7:0] typea_q;
	logic [7:0] typea_d;
	logic [7:0] rdata_d;
	logic field_prev_q;
	logic field_stable;
	logic mode_wr;
	logic rate_wr;
	logic typea_wr;
	logic [7:0] read_mux;
	logic [3:0] opcode;
	logic [3:0] tx_code;
	logic [3:0] rx_code;
	logic [3:0] pw_code;
	logic tx_valid;
	logic rx_valid;
	logic [2:0] tx_div;
	logic [2:0] rx_div;
	protocol_t proto;
	logic enable_d;
	logic [7:0] pw_result;
	logic field_lost;
	logic ca_start_d;
	mode_sel_t mode_sel_d;
	rate_sel_t rate_sel_d;
	framing_t framing_d;

	// Write decode
	assign mode_wr = reg_wr_i && (reg_addr_i == MODE_ADDR);
	assign rate_wr = reg_wr_i && (reg_addr_i == RATE_ADDR);
	assign typea_wr = reg_wr_i && (reg_addr_i == TYPEA_ADDR);

	// Set-default beats the go-normal load, which beats a host write
	assign mode_d = set_default_cmd_i ? MODE_RESET :
		mode_wr ? (reg_wdata_i & MODE_RW_MASK) : mode_q;
	assign rate_d = set_default_cmd_i ? RATE_RESET :
		go_normal_cmd_i ? detected_rate_i :
		rate_wr ? reg_wdata_i : rate_q;
	assign typea_d = set_default_cmd_i ? TYPEA_RESET :
		typea_wr ? reg_wdata_i : typea_q;

	// Read decode; unmapped offsets read zero
	assign read_mux = (reg_addr_i == MODE_ADDR) ? mode_q :
		(reg_addr_i == RATE_ADDR) ? rate_q :
		(reg_addr_i == TYPEA_ADDR) ? typea_q : 8'h00;
	assign rdata_d = reg_rd_i ? read_mux : 8'h00;

	// Field slices
	assign opcode = mode_q[OPCODE_MSB:OPCODE_LSB];
	assign tx_code = rate_q[TX_RATE_MSB:TX_RATE_LSB];
	assign rx_code = rate_q[RX_RATE_MSB:RX_RATE_LSB];
	assign pw_code = typea_q[PW_MSB:PW_LSB];

	speed_code_decode #(
		.W(CODE_W)
	) u_tx_speed (
		.code_i(tx_code),
		.valid_o(tx_valid),
		.div_log2_o(tx_div)
	);

	speed_code_decode #(
		.W(CODE_W)
	) u_rx_speed (
		.code_i(rx_code),
		.valid_o(rx_valid),
		.div_log2_o(rx_div)
	);

	// The opcode means different things in the two roles
	function automatic protocol_t proto_decode(input logic target, input logic [3:0] op);
		protocol_t p;
		p = PROTO_NONE;
		if (target) begin
			case (op)
				OP_TGT_AUTORATE: p = PROTO_TGT_AUTORATE;
				OP_TGT_NORMAL: p = PROTO_TGT_NORMAL;
				default: p = PROTO_NONE;
			endcase
		end else begin
			case (op)
				OP_NFC_ACTIVE: p = PROTO_NFC_ACTIVE;
				OP_TYPE_A: p = PROTO_TYPE_A;
				OP_TYPE_B: p = PROTO_TYPE_B;
				OP_JP: p = PROTO_JP;
				OP_T1T: p = PROTO_T1T;
				OP_SUBC: p = PROTO_SUBC_STREAM;
				OP_BPSK: p = PROTO_BPSK_STREAM;
				default: p = PROTO_NONE;
			endcase
		end
		return p;
	endfunction

	// Pulse width from the signed code; bit 7 of the result marks a listed code.
	// The fc/64 column folds back above +4, so it is not a plain offset there.
	function automatic logic [7:0] pulse_lookup(input logic [3:0] speed, input logic [3:0] c);
		logic [6:0] sx;
		logic signed [4:0] sv;
		logic [7:0] r;
		sx = {{3{c[3]}}, c};
		sv = $signed({c[3], c});
		r = 8'h00;
		case (speed)
			RATE_FC128: r = {1'b1, 7'(PW_BASE_FC128 + sx)};
			RATE_FC64: begin
				if (sv >= -5'sd6 && sv <= 5'sd4) begin
					r = {1'b1, 7'(PW_BASE_FC64 + sx)};
				end else if (sv > 5'sd4 && sv <= 5'sd6) begin
					r = {1'b1, 7'(PW_FOLD_FC64 - sx)};
				end
			end
			RATE_FC32: begin
				if (sv >= -5'sd4 && sv <= 5'sd4) begin
					r = {1'b1, 7'(PW_BASE_FC32 + sx)};
				end
			end
			RATE_FC16: begin
				if (sv >= -5'sd3 && sv <= 5'sd3) begin
					r = {1'b1, 7'(PW_BASE_FC16 + sx)};
				end
			end
			default: r = 8'h00;
		endcase
		return r;
	endfunction

	assign proto = proto_decode(mode_q[ROLE_BIT], opcode);
	// Any unsupported mode or speed code keeps the transceiver off
	assign enable_d = (proto != PROTO_NONE) && tx_valid && rx_valid;
	assign pw_result = pulse_lookup(tx_code, pw_code);

	assign mode_sel_d.target = mode_q[ROLE_BIT];
	assign mode_sel_d.proto = proto;
	assign rate_sel_d.tx_div_log2 = tx_div;
	assign rate_sel_d.rx_div_log2 = rx_div;
	assign framing_d.tx_parity_off = typea_q[NO_TX_PAR_BIT];
	assign framing_d.rx_raw = typea_q[NO_RX_PAR_BIT];
	assign framing_d.transport_header = typea_q[HDR_BIT];
	assign framing_d.anticoll_frame = typea_q[ANTICOLL_BIT];
	assign framing_d.pulse_width_valid = pw_result[7];
	assign framing_d.pulse_width = pw_result[6:0];

	// Field loss is taken on the filtered level, so a glitch cannot fire it
	level_sync3 u_field_sync (
		.clk_i(core_clk_i),
		.rst_i(rst_i),
		.d_i(ext_field_i),
		.q_o(field_stable)
	);
	assign field_lost = field_prev_q && !field_stable;
	assign ca_start_d = field_lost && mode_q[AUTO_CA_BIT];

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			mode_q <= MODE_RESET;
			rate_q <= RATE_RESET;
			typea_q <= TYPEA_RESET;
		end else begin
			mode_q <= mode_d;
			rate_q <= rate_d;
			typea_q <= typea_d;
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			reg_rdata_o <= 8'h00;
			field_prev_q <= 1'b0;
			collision_avoid_start_o <= 1'b0;
		end else begin
			reg_rdata_o <= rdata_d;
			field_prev_q <= field_stable;
			collision_avoid_start_o <= ca_start_d;
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			mode_o <= '0;
			rate_o <= '0;
			framing_o <= '0;
			txrx_enable_o <= 1'b0;
			start_byte_o <= 8'h00;
		end else begin
			mode_o <= mode_sel_d;
			rate_o <= rate_sel_d;
			framing_o <= framing_d;
			txrx_enable_o <= enable_d;
			start_byte_o <= typea_q[HDR_BIT] ? TRANSPORT_START_BYTE : 8'h00;
		end
	end

	// Checks
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);

	sequence field_loss_s;
		mode_q[AUTO_CA_BIT] && field_prev_q && !field_stable;
	endsequence

	sequence ca_pulse_s;
		collision_avoid_start_o ##1 !collision_avoid_start_o;
	endsequence

	sequence read_mode_s;
		reg_rd_i && (reg_addr_i == MODE_ADDR);
	endsequence

	chk_ca_start_pulse: assert property (field_loss_s |=> ca_pulse_s)
		else $error("collision avoidance start missing after field loss");

	chk_ca_needs_cause: assert property (
		collision_avoid_start_o |-> $past(mode_q[AUTO_CA_BIT]) && $past(field_lost))
		else $error("collision avoidance started without field loss");

	chk_read_mode: assert property (read_mode_s |=> reg_rdata_o == $past(mode_q))
		else $error("mode register read back wrong");

	chk_read_idle_zero: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
		else $error("read data not zero outside read cycle");

	chk_reserved_zero: assert property (mode_q[2:1] == 2'b00)
		else $error("unused mode bits not zero");

	chk_write_readback: assert property (
		typea_wr && !set_default_cmd_i ##1 reg_rd_i && (reg_addr_i == TYPEA_ADDR)
		|=> reg_rdata_o == $past(reg_wdata_i, 2))
		else $error("framing register write not read back");

	chk_default_load: assert property (set_default_cmd_i |=>
		mode_q == 8'h08 && rate_q == 8'h00 && typea_q == 8'h00)
		else $error("set-default did not load defaults");

	chk_auto_rate_load: assert property (go_normal_cmd_i && !set_default_cmd_i
		|=> rate_q == $past(detected_rate_i))
		else $error("go-normal did not load speed register");

	chk_target_modes: assert property (mode_o.target |->
		mode_o.proto == PROTO_NONE || mode_o.proto == PROTO_TGT_AUTORATE ||
		mode_o.proto == PROTO_TGT_NORMAL)
		else $error("target role shows an initiator mode");

	chk_initiator_type_a: assert property (!mode_q[ROLE_BIT] && opcode == 4'h1
		|=> mode_o.proto == PROTO_TYPE_A && !mode_o.target)
		else $error("initiator opcode 1 not type A");

	chk_bad_mode_off: assert property (mode_q[ROLE_BIT] && opcode > 4'h1
		|=> !txrx_enable_o)
		else $error("unassigned target opcode left transceiver on");

	chk_bad_rate_off: assert property (tx_code > 4'h3 || rx_code > 4'h3
		|=> !txrx_enable_o)
		else $error("unassigned speed code left transceiver on");

	chk_tx_speed_fc16: assert property (tx_code == 4'h3 |=> rate_o.tx_div_log2 == 3'h4)
		else $error("fc/16 transmit speed not decoded");

	chk_pulse_centre: assert property (tx_code == 4'h0 && pw_code == 4'h0
		|=> framing_o.pulse_width == 7'h23 && framing_o.pulse_width_valid)
		else $error("pulse width centre not 35 at fc/128");

	chk_header_byte: assert property (typea_q[HDR_BIT] |=> start_byte_o == 8'hF0)
		else $error("transport start byte not F0");

	chk_raw_framing: assert property (typea_q[NO_TX_PAR_BIT] && typea_q[NO_RX_PAR_BIT]
		|=> framing_o.tx_parity_off && framing_o.rx_raw)
		else $error("raw framing flags not passed on");

	chk_target_normal: assert property (mode_q[ROLE_BIT] && opcode == 4'h1
		|=> mode_o.target && mode_o.proto == PROTO_TGT_NORMAL)
		else $error("target opcode 1 not normal active mode");

	chk_initiator_bpsk: assert property (!mode_q[ROLE_BIT] && opcode == 4'hF
		|=> mode_o.proto == PROTO_BPSK_STREAM)
		else $error("initiator opcode F not BPSK stream");

	chk_rx_speed_fc128: assert property (rx_code == 4'h0
		|=> rate_o.rx_div_log2 == 3'h7)
		else $error("fc/128 receive speed not decoded");

	chk_pulse_fold: assert property (tx_code == 4'h1 && pw_code == 4'h5
		|=> framing_o.pulse_width == 7'h15 && framing_o.pulse_width_valid)
		else $error("fc/64 code 5 pulse width not 21");

	chk_pulse_unlisted: assert property (tx_code == 4'h3 && pw_code == 4'h4
		|=> !framing_o.pulse_width_valid && framing_o.pulse_width == 7'h00)
		else $error("unlisted fc/16 pulse code marked valid");

	chk_header_off: assert property (!typea_q[HDR_BIT] |=> start_byte_o == 8'h00)
		else $error("start byte shown without transport header");

	chk_ca_disabled: assert property (!mode_q[AUTO_CA_BIT] |=> !collision_avoid_start_o)
		else $error("collision avoidance started while disabled");
endmodule
`default_nettype wire

// ### sim/host_port_model.sv
// Host side of the configuration register port: one-cycle write and read strobes.
// Assumes its tasks are entered just after a rising edge of clk_i.
`timescale 1ns/1ns
`default_nettype none
module host_port_model (
	// Clock
	input wire logic clk_i,
	// Register port
	output logic [7:0] addr_o,
	output logic [7:0] wdata_o,
	output logic wr_o,
	output logic rd_o,
	input wire logic [7:0] rdata_i
);
	initial begin
		addr_o = 8'h00;
		wdata_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	// Idle bus shows the inverse, so a stale value never passes for a live request.
	// Raw-stream, raw-receive and anticollision bits are written only as the caller
	// commands; keeping them consistent with the mode is the caller's duty
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~d;
		#1;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		#1 d = rdata_i;
	endtask
endmodule
`default_nettype wire

// ### sim/tb_nfc_protocol_mode_config.sv
// Self-checking bench for the protocol mode configuration bank.
// Assumes the host model drives the register port; commands and field come from here.
`timescale 1ns/1ns
`default_nettype none
module tb_nfc_protocol_mode_config;
	import nfc_mode_pkg::*;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic reg_wr, reg_rd;
	logic set_default_cmd = 1'b0;
	logic go_normal_cmd = 1'b0;
	logic [7:0] detected_rate = 8'h00;
	logic ext_field = 1'b1;
	mode_sel_t mode_o;
	rate_sel_t rate_o;
	framing_t framing_o;
	logic txrx_enable_o, collision_avoid_start_o;
	logic [7:0] start_byte_o;
	int err_count = 0;
	int n_tests = 0;
	int seed = 1;
	int m_mode, m_rate, m_typea;
	always #50 core_clk_i = ~core_clk_i;
	host_port_model h (.clk_i(core_clk_i), .addr_o(reg_addr), .wdata_o(reg_wdata),
		.wr_o(reg_wr), .rd_o(reg_rd), .rdata_i(reg_rdata));
	nfc_protocol_mode_config dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
		.reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .set_default_cmd_i(set_default_cmd),
		.go_normal_cmd_i(go_normal_cmd), .detected_rate_i(detected_rate),
		.ext_field_i(ext_field), .mode_o(mode_o), .rate_o(rate_o), .framing_o(framing_o),
		.txrx_enable_o(txrx_enable_o), .start_byte_o(start_byte_o),
		.collision_avoid_start_o(collision_avoid_start_o));
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic check(input string name, input int exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp[7:0]) begin
			err_count++;
			$display("[ERR] %s expected %0h seen %0h", name, exp[7:0], got);
		end
	endtask
	function automatic int proto_exp(input int m);
		int op;
		op = (m >> 3) & 15;
		if (m >= 128) begin
			return op < 2 ? 8 + op : 0;
		end
		case (op)
			0, 1, 2, 3, 4: return op + 1;
			14, 15: return op - 8;
			default: return 0;
		endcase
	endfunction
	function automatic int div_exp(input int c);
		return c < 4 ? 7 - c : 0;
	endfunction
	// Width in carrier periods, or -1 where the code has no meaning at that speed
	function automatic int pw_exp(input int t, input int p);
		int s;
		s = p > 7 ? p - 16 : p;
		case (t)
			0: return 35 + s;
			1: return (s >= -6 && s <= 4) ? 18 + s : (s == 5 ? 21 : (s == 6 ? 20 : -1));
			2: return (s >= -4 && s <= 4) ? 9 + s : -1;
			3: return (s >= -3 && s <= 3) ? 5 + s : -1;
			default: return -1;
		endcase
	endfunction
	task automatic check_all();
		int p, t, r, w;
		logic [7:0] d;
		p = proto_exp(m_mode);
		t = (m_rate >> 4) & 15;
		r = m_rate & 15;
		w = pw_exp(t, (m_typea >> 1) & 15);
		@(posedge core_clk_i);
		#1;
		check("target", m_mode >> 7, mode_o.target);
		check("proto", p, mode_o.proto);
		check("txrx_enable", p != 0 && t < 4 && r < 4, txrx_enable_o);
		check("tx_div", div_exp(t), rate_o.tx_div_log2);
		check("rx_div", div_exp(r), rate_o.rx_div_log2);
		check("tx_parity_off", m_typea >> 7, framing_o.tx_parity_off);
		check("rx_raw", (m_typea >> 6) & 1, framing_o.rx_raw);
		check("header", (m_typea >> 5) & 1, framing_o.transport_header);
		check("start_byte", (m_typea & 32) ? 8'hF0 : 0, start_byte_o);
		check("anticoll", m_typea & 1, framing_o.anticoll_frame);
		check("pw_valid", w >= 0, framing_o.pulse_width_valid);
		check("pw", w < 0 ? 0 : w, framing_o.pulse_width);
		h.rd_reg(MODE_ADDR, d);
		check("mode_reg", m_mode, d);
		h.rd_reg(RATE_ADDR, d);
		check("rate_reg", m_rate, d);
		h.rd_reg(TYPEA_ADDR, d);
		check("typea_reg", m_typea, d);
	endtask
	task automatic field_step(input logic lvl, input int exp_n);
		int n;
		n = 0;
		ext_field <= lvl;
		repeat (10) begin
			@(posedge core_clk_i);
			#1;
			if (collision_avoid_start_o === 1'b1) n++;
		end
		check("collision_pulses", exp_n, n[7:0]);
	endtask
	initial begin
		#2_000_000;
		err_count++;
		close_out();
	end
	initial begin
		int v, t;
		logic [7:0] d;
		repeat (6) @(posedge core_clk_i);
		rst_i <= 1'b0;
		#1;
		m_mode = 8;
		m_rate = 0;
		m_typea = 0;
		check_all();
		h.wr_reg(8'h02, 8'hFF);
		h.rd_reg(8'h06, d);
		check("unmapped", 0, d);
		check_all();
		for (int i = 0; i < 32; i++) begin
			v = ((i & 16) << 3) | ((i & 15) << 3) | 6;
			h.wr_reg(MODE_ADDR, v[7:0]);
			m_mode = v & 8'hF9;
			check_all();
		end
		h.wr_reg(MODE_ADDR, 8'h08);
		m_mode = 8;
		for (int tc = 0; tc < 5; tc++) begin
			for (int p = 0; p < 16; p++) begin
				t = tc < 4 ? tc : 4 + ($unsigned($random(seed)) % 12);
				m_rate = (t << 4) | ($random(seed) & 7);
				m_typea = ($random(seed) & 8'hE1) | (p << 1);
				h.wr_reg(RATE_ADDR, m_rate[7:0]);
				h.wr_reg(TYPEA_ADDR, m_typea[7:0]);
				check_all();
			end
		end
		d = $random(seed) & 8'h33;
		detected_rate <= d;
		go_normal_cmd <= 1'b1;
		h.wr_reg(RATE_ADDR, 8'hFF);
		go_normal_cmd <= 1'b0;
		m_rate = d;
		check_all();
		h.wr_reg(MODE_ADDR, 8'h89);
		set_default_cmd <= 1'b1;
		h.wr_reg(TYPEA_ADDR, 8'hFF);
		set_default_cmd <= 1'b0;
		m_mode = 8;
		m_rate = 0;
		m_typea = 0;
		check_all();
		h.wr_reg(TYPEA_ADDR, 8'hA5);
		h.rd_reg(TYPEA_ADDR, d);
		check("typea_back_to_back", 8'hA5, d);
		m_typea = 8'hA5;
		check_all();
		h.wr_reg(MODE_ADDR, 8'h09);
		field_step(1'b0, 1);
		field_step(1'b1, 0);
		h.wr_reg(MODE_ADDR, 8'h08);
		field_step(1'b0, 0);
		close_out();
	end
endmodule
`default_nettype wire
